/* File: bank_reset_clock_pkg.sv */
package bank_reset_clock_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [6:0] BANK_SELECT_OFFSET   = 7'h00;
    localparam logic [6:0] SW_RESET_OFFSET      = 7'h01;
    localparam logic [6:0] CLOCK_GATING_OFFSET  = 7'h02;
    localparam logic [6:0] OSC_SOURCE_OFFSET    = 7'h03;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] BANK_SELECT_RESET    = 8'h11;
    localparam logic [7:0] SW_RESET_RESET       = 8'h00;
    localparam logic [5:0] CLOCK_GATING_RESET   = 6'h3f;
    localparam logic [7:0] OSC_SOURCE_RESET     = 8'h9b;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int         CLK_STABLE_BIT       = 7;
    localparam int         MASTER_CLK_BIT       = 7;
    localparam int         EXT_REF_OSC_BIT      = 6;
    localparam int         CRYSTAL_OSC_BIT      = 4;
    localparam int         RC_OSC_BIT           = 3;
    localparam int         PA_REG_BIT           = 1;
    localparam int         RX_SLOW_BIT          = 0;
    localparam logic [7:0] OSC_KEEP_MASK        = 8'h78;
    localparam logic [7:0] OSC_WRITE_MASK       = 8'hdf;
    localparam int         DOMAIN_CFG           = 0;

    // ------------------------------------------------------------------
    // Bank codes
    // ------------------------------------------------------------------
    localparam logic [3:0] BANK0_CODE           = 4'h1;
    localparam logic [3:0] BANK1_CODE           = 4'h2;
    localparam logic [3:0] BANK2_CODE           = 4'h4;
    localparam logic [3:0] BANK3_CODE           = 4'h8;
    localparam logic [3:0] BANK6_CODE           = 4'h3;
    localparam logic [3:0] BANK7_CODE           = 4'h5;
    localparam logic [3:0] BANK10_CODE          = 4'h9;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         SYS_CLK_PERIOD_PS    = 25000;
    localparam int         RESET_DONE_TIME_NS   = 2000;
    localparam int         RESET_DONE_CYCLES    =
        (RESET_DONE_TIME_NS * 1000) / SYS_CLK_PERIOD_PS;
    localparam logic [6:0] RESET_COUNT_LOAD     = 7'(RESET_DONE_CYCLES - 1);

    typedef enum logic [2:0] {
        RST_IDLE    = 3'b001,
        RST_WAIT    = 3'b010,
        RST_DEFER   = 3'b100
    } reset_state_e;

endpackage

/* File: bank_reset_clock_control.sv */
`timescale 1ns/10ps
// Operation
// [RQ1] Bank fields use one-hot-ish codes, reset 0x11
// [RQ2] Host avoids bank2 during VCO calibration
// [RQ3] Accesses allowed before clock stable flag
// [RQ4] Reset runs only with guard plus execute
// [RQ5] Device self-clears guard and execute bits
// [RQ6] Awake reset completes 2 us after write
// [RQ7] Sleep defers reset to clock-stable interrupt
// [RQ8] Latest written reset value is acted upon
// [RQ9] Execute bits: PHY, RF, modem, config
// [RQ10] Config reset keeps oscillator bits 6:3
// [RQ11] FIFO contents undefined after config reset
// [RQ12] Bit 7 clock stable flag, bit 6 zero
// [RQ13] Six clock gates, reset 0x3F
// [RQ14] Oscillator bit 7 master clock, reset 0x9B
// [RQ15] Oscillator bit 3 internal RC enable
// [RQ16] Bit 0 rx slowdown, bit 1 PA regulator
// [RQ17] Host keeps one of TCXO, crystal enabled
// [RQ18] TCXO/crystal bits survive config reset
// [RQ19] Host programs oscillator register first
// [RQ20] Host access steered to selected bank
module bank_reset_clock_control (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [6:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    output logic      [3:0] bankAccess,
    output logic      [3:0] activeBank,
    output logic            bankZeroSel,
    output logic            bankOtherWrite,
    output logic            bankOtherRead,
    input  wire logic       sleepEnable,
    input  wire logic       clockStableIrq,
    input  wire logic       clockStable,
    output logic      [3:0] domainResetPulse,
    output logic      [5:0] clockGateEnable,
    output logic            logicMasterClockEnable,
    output logic            externalRefOscEnable,
    output logic            crystalOscEnable,
    output logic            internalRcOscEnable,
    output logic            paRegulatorRxOff,
    output logic            rxClockSlowdown,
    output logic            fifoContentsInvalid
);

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
        return addr == off;
    endfunction

    typedef bank_reset_clock_pkg::reset_state_e reset_state_e_t;

    logic       bankSelHit;
    logic       bank0;
    logic       wrBank0;
    logic       cfgReset;
    logic [7:0] bankSel_reg;
    logic [7:0] bankSel_next;
    logic [7:0] rstCtrl_reg;
    logic [7:0] rstCtrl_next;
    logic [5:0] clkGate_reg;
    logic [5:0] clkGate_next;
    logic [7:0] osc_reg;
    logic [7:0] osc_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic [3:0] pulse_reg;
    logic [3:0] pulse_next;
    logic       fifoBad_reg;
    logic       fifoBad_next;
    logic [6:0] count_reg;
    logic [6:0] count_next;
    reset_state_e_t state_reg;

    // Bank-select register is reachable from every bank so the host can always move.
    assign bankSelHit     = hit(regAddr, bank_reset_clock_pkg::BANK_SELECT_OFFSET); // RQ20
    assign bank0          = bankSel_reg[3:0] == bank_reset_clock_pkg::BANK0_CODE; // RQ1
    assign wrBank0        = regWrite && (bank0 || bankSelHit); // RQ20
    assign bankOtherWrite = regWrite && !bank0 && !bankSelHit; // RQ20
    assign bankOtherRead  = regRead && !bank0 && !bankSelHit; // RQ20
    assign bankZeroSel    = bank0;
    assign bankAccess     = bankSel_reg[7:4];
    assign activeBank     = bankSel_reg[3:0];
    assign cfgReset       = pulse_reg[bank_reset_clock_pkg::DOMAIN_CFG];

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    reset_state_e_t state_next;
    logic           rstWrite;
    logic [3:0]     armed;

    assign rstWrite = wrBank0 && hit(regAddr, bank_reset_clock_pkg::SW_RESET_OFFSET);
    // An execute bit counts only with its guard bit in the same value.
    assign armed    = rstCtrl_reg[7:4] & rstCtrl_reg[3:0]; // RQ4

    always_comb begin
        state_next   = state_reg;
        count_next   = count_reg;
        rstCtrl_next = rstCtrl_reg;
        pulse_next   = 4'h0;
        fifoBad_next = fifoBad_reg;
        case (state_reg)
            bank_reset_clock_pkg::RST_IDLE: begin
                if (armed != 4'h0) begin
                    if (sleepEnable) begin
                        state_next = bank_reset_clock_pkg::RST_DEFER; // RQ7
                    end else begin
                        state_next = bank_reset_clock_pkg::RST_WAIT;
                        count_next = bank_reset_clock_pkg::RESET_COUNT_LOAD; // RQ6
                    end
                end else begin
                    rstCtrl_next = 8'h00;
                end
            end
            bank_reset_clock_pkg::RST_WAIT: begin
                if (count_reg == 7'h00) begin
                    pulse_next   = armed; // RQ8 RQ9
                    rstCtrl_next = 8'h00; // RQ5
                    state_next   = bank_reset_clock_pkg::RST_IDLE;
                end else begin
                    count_next = count_reg - 7'h01;
                end
            end
            bank_reset_clock_pkg::RST_DEFER: begin
                if (clockStableIrq) begin
                    pulse_next   = armed; // RQ7 RQ8
                    rstCtrl_next = 8'h00; // RQ5
                    state_next   = bank_reset_clock_pkg::RST_IDLE;
                end
            end
            default: begin
                state_next   = bank_reset_clock_pkg::RST_IDLE;
                rstCtrl_next = 8'h00;
            end
        endcase
        // A rewrite restarts the wait and replaces the pending request.
        if (rstWrite) begin
            rstCtrl_next = regWrData; // RQ8
            if (state_reg == bank_reset_clock_pkg::RST_WAIT) begin
                state_next = bank_reset_clock_pkg::RST_IDLE;
                pulse_next = 4'h0;
            end
        end
        if (pulse_next[bank_reset_clock_pkg::DOMAIN_CFG]) begin
            fifoBad_next = 1'b1; // RQ11
        end else if (rstWrite) begin
            fifoBad_next = fifoBad_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg   <= bank_reset_clock_pkg::RST_IDLE;
            count_reg   <= 7'h00;
            rstCtrl_reg <= bank_reset_clock_pkg::SW_RESET_RESET;
            pulse_reg   <= 4'h0;
            fifoBad_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            count_reg   <= count_next;
            rstCtrl_reg <= rstCtrl_next;
            pulse_reg   <= pulse_next;
            fifoBad_reg <= fifoBad_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        bankSel_next = bankSel_reg;
        clkGate_next = clkGate_reg;
        osc_next     = osc_reg;
        if (cfgReset) begin
            bankSel_next = bank_reset_clock_pkg::BANK_SELECT_RESET; // RQ10
            clkGate_next = bank_reset_clock_pkg::CLOCK_GATING_RESET; // RQ10
            osc_next     = (bank_reset_clock_pkg::OSC_SOURCE_RESET
                            & ~bank_reset_clock_pkg::OSC_KEEP_MASK)
                           | (osc_reg & bank_reset_clock_pkg::OSC_KEEP_MASK); // RQ10 RQ18
        end else if (wrBank0) begin
            if (bankSelHit) begin
                bankSel_next = regWrData; // RQ1
            end
            if (hit(regAddr, bank_reset_clock_pkg::CLOCK_GATING_OFFSET)) begin
                clkGate_next = regWrData[5:0]; // RQ13
            end
            if (hit(regAddr, bank_reset_clock_pkg::OSC_SOURCE_OFFSET)) begin
                osc_next = regWrData & bank_reset_clock_pkg::OSC_WRITE_MASK; // RQ14 RQ19
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bankSel_reg <= bank_reset_clock_pkg::BANK_SELECT_RESET;
            clkGate_reg <= bank_reset_clock_pkg::CLOCK_GATING_RESET;
            osc_reg     <= bank_reset_clock_pkg::OSC_SOURCE_RESET;
        end else begin
            bankSel_reg <= bankSel_next;
            clkGate_reg <= clkGate_next;
            osc_reg     <= osc_next;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rdData_next = rdData_reg;
        if (regRead && (bank0 || bankSelHit)) begin
            case (regAddr)
                bank_reset_clock_pkg::BANK_SELECT_OFFSET:  rdData_next = bankSel_reg;
                bank_reset_clock_pkg::SW_RESET_OFFSET:     rdData_next = rstCtrl_reg;
                // Readable before the stable flag sets.
                bank_reset_clock_pkg::CLOCK_GATING_OFFSET:
                    rdData_next = {clockStable, 1'b0, clkGate_reg}; // RQ3 RQ12
                bank_reset_clock_pkg::OSC_SOURCE_OFFSET:   rdData_next = osc_reg;
                default:                                   rdData_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_reg <= 8'h00;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData              = rdData_reg;
    assign domainResetPulse       = pulse_reg; // RQ9
    assign clockGateEnable        = clkGate_reg; // RQ13
    assign logicMasterClockEnable = osc_reg[bank_reset_clock_pkg::MASTER_CLK_BIT]; // RQ14
    assign externalRefOscEnable   = osc_reg[bank_reset_clock_pkg::EXT_REF_OSC_BIT]; // RQ18
    assign crystalOscEnable       = osc_reg[bank_reset_clock_pkg::CRYSTAL_OSC_BIT]; // RQ18
    assign internalRcOscEnable    = osc_reg[bank_reset_clock_pkg::RC_OSC_BIT]; // RQ15
    assign paRegulatorRxOff       = osc_reg[bank_reset_clock_pkg::PA_REG_BIT]; // RQ16
    assign rxClockSlowdown        = osc_reg[bank_reset_clock_pkg::RX_SLOW_BIT]; // RQ16
    assign fifoContentsInvalid    = fifoBad_reg; // RQ11

    // ------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------
    // Cycles spent waiting, counted apart from the sequencer's own counter.
    logic [6:0] waitAge_reg;
    logic [6:0] waitAge_next;

    always_comb begin
        waitAge_next = 7'h00;
        if (state_reg == bank_reset_clock_pkg::RST_WAIT) begin
            waitAge_next = waitAge_reg + 7'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            waitAge_reg <= 7'h00;
        end else begin
            waitAge_reg <= waitAge_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_awake_reset_delay: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
        (state_reg == bank_reset_clock_pkg::RST_WAIT) && !rstWrite
        && (waitAge_reg == bank_reset_clock_pkg::RESET_COUNT_LOAD) |=> (pulse_reg != 4'h0))
        else $error("awake reset not completed on time");
    chk_awake_not_early: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ6
        (state_reg == bank_reset_clock_pkg::RST_WAIT)
        && (waitAge_reg < bank_reset_clock_pkg::RESET_COUNT_LOAD) |=> (pulse_reg == 4'h0))
        else $error("awake reset completed too early");
    chk_guard_needed: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ4
        (pulse_reg != 4'h0) |-> ((pulse_reg & ~$past(rstCtrl_reg[7:4])) == 4'h0))
        else $error("reset pulse without guard bit");
    chk_self_clear: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ5
        (pulse_reg != 4'h0) && !$past(rstWrite) |-> rstCtrl_reg == 8'h00)
        else $error("reset bits not cleared");
    chk_sleep_defer: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ7
        (state_reg == bank_reset_clock_pkg::RST_DEFER) && !clockStableIrq
        |=> (pulse_reg == 4'h0))
        else $error("reset ran during sleep");
    chk_cfg_keeps_osc: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ10
        cfgReset |=> ((osc_reg & bank_reset_clock_pkg::OSC_KEEP_MASK)
                      == ($past(osc_reg) & bank_reset_clock_pkg::OSC_KEEP_MASK)))
        else $error("config reset altered oscillator bits");
    chk_cfg_gates_back: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ13
        cfgReset |=> clockGateEnable == bank_reset_clock_pkg::CLOCK_GATING_RESET)
        else $error("clock gates not restored");
    chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ12
        $past(regRead && bank0 && regAddr == bank_reset_clock_pkg::CLOCK_GATING_OFFSET)
        |-> regRdData[6] == 1'b0 && regRdData[7] == $past(clockStable))
        else $error("clock gating readback wrong");
    chk_bank_steer: assert property (@(posedge sys_clk) disable iff (!rst_b) // RQ20
        regWrite && !bank0 && !cfgReset && regAddr == bank_reset_clock_pkg::CLOCK_GATING_OFFSET
        |=> $stable(clockGateEnable))
        else $error("write leaked into bank zero");

endmodule // bank_reset_clock_control

/* File: host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Serial host acting on the register strobes
// ----------------------------------------------------------------------
module host_model (
    input  wire logic       sys_clk,
    output logic            regWrite,
    output logic            regRead,
    output logic      [6:0] regAddr,
    output logic      [7:0] regWrData,
    input  wire logic [7:0] regRdData
);
    initial begin
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regAddr   = 7'h00;
        regWrData = 8'h00;
    end

    // Data is inverted once released so a stale byte is never mistaken for a live one.
    task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrite  <= 1'b0;
        regWrData <= ~d;
    endtask

    task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
endmodule // host_model

/* File: tb_bank_reset_clock_control.sv */
`timescale 1ns/10ps
module tb_bank_reset_clock_control;
    typedef struct packed {
        logic       wr;
        logic [6:0] a;
        logic [7:0] d;
        logic       st;
        logic [7:0] e;
    } row_s;

    logic sys_clk, rst_b, regWrite, regRead, bankZeroSel, bankOtherWrite, bankOtherRead;
    logic sleepEnable, clockStableIrq, clockStable, fifoContentsInvalid;
    logic logicMasterClockEnable, externalRefOscEnable, crystalOscEnable;
    logic internalRcOscEnable, paRegulatorRxOff, rxClockSlowdown;
    logic [6:0] regAddr;
    logic [7:0] regWrData, regRdData, rd;
    logic [3:0] bankAccess, activeBank, domainResetPulse, p;
    logic [5:0] clockGateEnable;
    int         bad_count = 0;
    int         comparisons = 0;
    int         n;
    int         otherWrites = 0;
    int         otherReads = 0;
    row_s       rows[8] = '{
        '{1'b0, 7'h00, 8'h00, 1'b0, 8'h11},
        '{1'b0, 7'h01, 8'h00, 1'b0, 8'h00},
        '{1'b0, 7'h02, 8'h00, 1'b0, 8'h3f},
        '{1'b0, 7'h03, 8'h00, 1'b0, 8'h9b},
        '{1'b0, 7'h10, 8'h00, 1'b0, 8'h00},
        '{1'b0, 7'h02, 8'h00, 1'b1, 8'hbf},
        '{1'b1, 7'h03, 8'hed, 1'b1, 8'hcd},
        '{1'b1, 7'h02, 8'hea, 1'b1, 8'haa}};

    host_model u_host_model (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));

    bank_reset_clock_control u_bank_reset_clock_control (.sys_clk(sys_clk), .rst_b(rst_b),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .bankAccess(bankAccess), .activeBank(activeBank),
        .bankZeroSel(bankZeroSel), .bankOtherWrite(bankOtherWrite),
        .bankOtherRead(bankOtherRead), .sleepEnable(sleepEnable),
        .clockStableIrq(clockStableIrq), .clockStable(clockStable),
        .domainResetPulse(domainResetPulse), .clockGateEnable(clockGateEnable),
        .logicMasterClockEnable(logicMasterClockEnable),
        .externalRefOscEnable(externalRefOscEnable), .crystalOscEnable(crystalOscEnable),
        .internalRcOscEnable(internalRcOscEnable), .paRegulatorRxOff(paRegulatorRxOff),
        .rxClockSlowdown(rxClockSlowdown), .fifoContentsInvalid(fifoContentsInvalid));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wait_pulse(input int lim);
        n = 0;
        p = 4'h0;
        while (n < lim && p === 4'h0) begin
            @(posedge sys_clk);
            #1;
            n++;
            p = domainResetPulse;
        end
    endtask

    task automatic run_reset(input logic [7:0] v, input logic [3:0] e);
        u_host_model.write_reg(7'h01, v);
        wait_pulse(200);
        check("pulse", {4'h0, e}, {4'h0, p});
        check("delay ok", 8'h01, {7'h00, n >= 80 && n <= 83});
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        finish_test();
    end

    // Counts the strobes that the design forwards to the other banks.
    always @(posedge sys_clk) begin
        if (bankOtherWrite === 1'b1)
            otherWrites++;
        if (bankOtherRead === 1'b1)
            otherReads++;
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b          = 1'b0;
        sleepEnable    = 1'b0;
        clockStableIrq = 1'b0;
        clockStable    = 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            clockStable <= rows[i].st;
            if (rows[i].wr)
                u_host_model.write_reg(rows[i].a, rows[i].d);
            u_host_model.read_reg(rows[i].a, rd);
            check("register row", rows[i].e, rd);
        end
        check("gates", 8'h2a, {2'b00, clockGateEnable});
        check("osc outs", 8'h35, {2'b00, logicMasterClockEnable, externalRefOscEnable,
            crystalOscEnable, internalRcOscEnable, paRegulatorRxOff, rxClockSlowdown});
        $display("table test done");
        u_host_model.write_reg(7'h00, 8'h22);
        #1;
        check("bank", 8'h22, {bankAccess, activeBank});
        check("bank0 sel", 8'h00, {7'h00, bankZeroSel});
        u_host_model.write_reg(7'h01, 8'h11);
        wait_pulse(100);
        check("steered away", 8'h00, {4'h0, p});
        u_host_model.read_reg(7'h02, rd);
        check("foreign read", 8'haa, rd);
        check("other strobes", 8'h11, {otherWrites[3:0], otherReads[3:0]});
        u_host_model.write_reg(7'h00, 8'h11);
        $display("bank test done");
        run_reset(8'h11, 4'h1);
        repeat (2) @(posedge sys_clk);
        u_host_model.read_reg(7'h03, rd);
        check("osc kept", 8'hcb, rd);
        u_host_model.read_reg(7'h02, rd);
        check("gates reset", 8'hbf, rd);
        u_host_model.read_reg(7'h01, rd);
        check("reset cleared", 8'h00, rd);
        check("fifo flag", 8'h01, {7'h00, fifoContentsInvalid});
        for (int i = 1; i < 4; i++)
            run_reset(8'h11 << i, 4'h1 << i);
        $display("config test done");
        u_host_model.write_reg(7'h01, 8'h81);
        u_host_model.read_reg(7'h01, rd);
        check("unpaired cleared", 8'h00, rd);
        wait_pulse(120);
        check("unpaired", 8'h00, {4'h0, p});
        u_host_model.write_reg(7'h01, 8'h88);
        repeat (40) @(posedge sys_clk);
        run_reset(8'h44, 4'h4);
        $display("guard test done");
        @(posedge sys_clk);
        sleepEnable <= 1'b1;
        u_host_model.write_reg(7'h01, 8'h22);
        wait_pulse(150);
        check("deferred", 8'h00, {4'h0, p});
        @(posedge sys_clk);
        clockStableIrq <= 1'b1;
        sleepEnable    <= 1'b0;
        @(posedge sys_clk);
        clockStableIrq <= 1'b0;
        #1;
        p = domainResetPulse;
        if (p === 4'h0)
            wait_pulse(3);
        check("after wake", 8'h02, {4'h0, p});
        $display("sleep test done");
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        u_host_model.read_reg(7'h03, rd);
        check("pin reset osc", 8'h9b, rd);
        check("fifo flag pin", 8'h00, {7'h00, fifoContentsInvalid});
        $display("pin reset test done");
        finish_test();
    end
endmodule // tb_bank_reset_clock_control
